/* File: aoc_output_config.sv */
// aoc_output_config.sv: output configuration register of a class-d amplifier
// and the decoded controls it drives into the output stage.
// assumes: the control port delivers single-cycle read and write strobes in
// the sys_clk domain; double_speed comes from the clock detector, synchronous.
`timescale 1ns/10ps
`include "aoc_cfg.svh"

module aoc_output_config
  import aoc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control port register access
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  output logic rsvd_slot_hit,
  // sampling rate status
  input wire logic double_speed,
  // controls to the output stage
  output aoc_amp_ctl_s amp_ctl
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  aoc_cfg_s cfg_reg, cfg_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic rsvd_hit_reg, rsvd_hit_next;
  aoc_amp_ctl_s ctl_reg, ctl_next;
  aoc_speed_e speed;
  logic [4:0] mult;
  logic half;
  logic hit_cfg, hit_rsvd;

  // address decode
  always_comb begin
    hit_cfg = 1'b0;
    hit_rsvd = 1'b0;
    if (bus_addr == `AOC_ADDR_OUT_CFG) begin
      hit_cfg = 1'b1;
    end else if (bus_addr == `AOC_ADDR_RSVD_SLOT) begin
      hit_rsvd = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------------------
  // every field is stored as written, the reserved gain code included: the
  // host is trusted to avoid it and we only flag it downstream
  always_comb begin
    cfg_next = cfg_reg;
    if (bus_wr && hit_cfg) begin
      cfg_next = aoc_cfg_s'(bus_wdata);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_reg <= aoc_cfg_s'(`AOC_RST_WORD);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // a read in the same cycle as a write sees the old contents; the reserved
  // slot and unmapped addresses read as zero and writes to them are dropped
  always_comb begin
    rvalid_next = bus_rd;
    rsvd_hit_next = (bus_rd || bus_wr) && hit_rsvd;
    rdata_next = rdata_reg;
    if (bus_rd) begin
      if (hit_cfg) begin
        rdata_next = cfg_reg;
      end else begin
        rdata_next = `AOC_RSVD_READ;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      rsvd_hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      rsvd_hit_reg <= rsvd_hit_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign bus_rvalid = rvalid_reg;
  assign rsvd_slot_hit = rsvd_hit_reg;

  // ---------------------------------------------------------------------------
  // output stage controls
  // ---------------------------------------------------------------------------
  assign speed = double_speed ? AOC_SPEED_DOUBLE : AOC_SPEED_SINGLE;

  aoc_rate_decode u_rate (
    .rate_code(cfg_reg.rate_code),
    .speed(speed),
    .multiple(mult),
    .half_step(half)
  );

  // controls lag the register by one cycle so they leave flip-flops
  always_comb begin
    ctl_next.parallel_bridge_mode = cfg_reg.bridge_sel;
    ctl_next.bridge_tied_mode = ~cfg_reg.bridge_sel;
    ctl_next.switch_multiple = mult;
    ctl_next.switch_half_step = half;
    ctl_next.gain_step_code = cfg_reg.gain_code;
    ctl_next.gain_code_reserved = (cfg_reg.gain_code == `AOC_GAIN_RSVD);
    ctl_next.mono_source_channel_select = cfg_reg.chan_sel;
    // the channel choice only steers the stage in parallel bridge; in stereo
    // both channels run, so the feed is parked on the right channel
    ctl_next.feed_left = cfg_reg.bridge_sel & cfg_reg.chan_sel;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_reg <= '0;
      ctl_reg.bridge_tied_mode <= 1'b1;
      ctl_reg.switch_multiple <= `AOC_MULT_5;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign amp_ctl = ctl_reg;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_bridge_mode_follows: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && hit_cfg ##2 1'b1 |->
      amp_ctl.parallel_bridge_mode == $past(bus_wdata[`AOC_BIT_BRIDGE], 2)
      && amp_ctl.bridge_tied_mode != amp_ctl.parallel_bridge_mode)
    else $error("bridge mode does not follow bit 7");

  a_rate_single_speed: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && hit_cfg && bus_wdata[6:4] == 3'h6 ##1 !double_speed ##1
      !$past(bus_wr) |-> amp_ctl.switch_multiple == 5'h14)
    else $error("code 110 does not give twenty times");

  a_rate_double_speed: assert property (@(posedge sys_clk) disable iff (rst)
    double_speed && cfg_reg.rate_code == 3'h7 |=> amp_ctl.switch_multiple == 5'h0c)
    else $error("double speed does not halve the rate");

  a_gain_step_map: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && hit_cfg && bus_wdata[3:2] == 2'h1 ##1 !bus_wr [*1] |=>
      amp_ctl.gain_step_code == 2'h1 && !amp_ctl.gain_code_reserved)
    else $error("gain step 22.6 dBV not applied");

  a_gain_reset_low: assert property (@(posedge sys_clk)
    rst |=> cfg_reg.gain_code == 2'h0 ##1 rst || amp_ctl.gain_step_code == 2'h0)
    else $error("gain not at lowest step after reset");

  a_chan_sel_feed: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg_reg.bridge_sel |=> !amp_ctl.feed_left)
    else $error("channel select leaks into stereo operation");

  a_reserved_bit_reset: assert property (@(posedge sys_clk)
    rst |=> cfg_reg.rsvd == 1'b1 && cfg_reg.rate_code == 3'h5 && !cfg_reg.bridge_sel)
    else $error("reset word wrong");

  a_readback_last_write: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && hit_cfg ##1 bus_rd && hit_cfg && !bus_wr |=>
      bus_rvalid && bus_rdata == $past(bus_wdata, 2))
    else $error("read does not return last write");

  a_reserved_slot_zero: assert property (@(posedge sys_clk) disable iff (rst)
    bus_rd && hit_rsvd |=> bus_rdata == 8'h00 && rsvd_slot_hit)
    else $error("reserved slot read not zero or not flagged");

  // the reserved gain code and the reserved slot are host duties, so the
  // design only flags them; the checks below watch what it drives instead
  a_feed_left_parallel: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_reg.bridge_sel && cfg_reg.chan_sel |=> amp_ctl.feed_left)
    else $error("left channel not fed in parallel bridge");

  a_gain_code_copy: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> amp_ctl.gain_step_code == $past(cfg_reg.gain_code))
    else $error("gain step does not follow the register");

  a_rvalid_single_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    !bus_rd |=> !bus_rvalid)
    else $error("read valid without a read strobe");

  a_rate_reset_default: assert property (@(posedge sys_clk)
    rst ##1 !rst && !double_speed |=> amp_ctl.switch_multiple == 5'h10
      && amp_ctl.bridge_tied_mode)
    else $error("rate or topology not at default after reset");

  c_parallel_left: cover property (@(posedge sys_clk) disable iff (rst)
    amp_ctl.parallel_bridge_mode && amp_ctl.feed_left);
  c_double_speed: cover property (@(posedge sys_clk) disable iff (rst)
    double_speed && amp_ctl.switch_multiple == 5'h08);
  c_write_then_read: cover property (@(posedge sys_clk) disable iff (rst)
    bus_wr && hit_cfg ##1 bus_rd && hit_cfg);
  c_gain_top_step: cover property (@(posedge sys_clk) disable iff (rst)
    amp_ctl.gain_step_code == `AOC_GAIN_25P0);

endmodule : aoc_output_config

/* File: aoc_cfg.svh */
// aoc_cfg.svh: offsets, field positions, reset values and rate codes for the
// amplifier output configuration register bank.
// assumes: included by its bare name from the package and the design files.
`ifndef AOC_CFG_SVH
`define AOC_CFG_SVH

// -----------------------------------------------------------------------------
// addresses on the control port
// -----------------------------------------------------------------------------
`define AOC_ADDR_OUT_CFG 8'h06
`define AOC_ADDR_RSVD_SLOT 8'h07

// -----------------------------------------------------------------------------
// field positions of the output configuration register
// -----------------------------------------------------------------------------
`define AOC_BIT_BRIDGE 7
`define AOC_RATE_HI 6
`define AOC_RATE_LO 4
`define AOC_GAIN_HI 3
`define AOC_GAIN_LO 2
`define AOC_BIT_CHSEL 1
`define AOC_BIT_RSVD 0

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define AOC_RST_BRIDGE 1'h0
`define AOC_RST_RATE 3'h5
`define AOC_RST_GAIN 2'h0
`define AOC_RST_CHSEL 1'h0
`define AOC_RST_RSVD 1'h1
`define AOC_RST_WORD 8'h51
`define AOC_RSVD_READ 8'h00

// -----------------------------------------------------------------------------
// switching multiples of the frame clock, single speed
// -----------------------------------------------------------------------------
`define AOC_MULT_0 5'h06
`define AOC_MULT_1 5'h08
`define AOC_MULT_2 5'h0a
`define AOC_MULT_3 5'h0c
`define AOC_MULT_4 5'h0e
`define AOC_MULT_5 5'h10
`define AOC_MULT_6 5'h14
`define AOC_MULT_7 5'h18

// gain step codes
`define AOC_GAIN_19P2 2'h0
`define AOC_GAIN_22P6 2'h1
`define AOC_GAIN_25P0 2'h2
`define AOC_GAIN_RSVD 2'h3

`endif

/* File: aoc_pkg.sv */
// aoc_pkg.sv: types shared by the output configuration register bank.
// assumes: aoc_cfg.svh is on the include path.
`include "aoc_cfg.svh"

package aoc_pkg;

  // ---------------------------------------------------------------------------
  // register layout and decoded view
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       bridge_sel;   // 1 = parallel bridge
    logic [2:0] rate_code;
    logic [1:0] gain_code;
    logic       chan_sel;     // 1 = left
    logic       rsvd;
  } aoc_cfg_s;

  typedef struct packed {
    logic       parallel_bridge_mode;
    logic       bridge_tied_mode;
    logic [4:0] switch_multiple;
    logic       switch_half_step;
    logic [1:0] gain_step_code;
    logic       gain_code_reserved;
    logic       mono_source_channel_select;
    logic       feed_left;
  } aoc_amp_ctl_s;

  typedef enum logic [1:0] {
    AOC_SPEED_SINGLE = 2'b01,
    AOC_SPEED_DOUBLE = 2'b10
  } aoc_speed_e;

endpackage : aoc_pkg

/* File: aoc_rate_decode.sv */
// aoc_rate_decode.sv: maps the switching-rate code to a multiple of the frame
// clock, halved in double-speed mode.
// assumes: purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "aoc_cfg.svh"

module aoc_rate_decode
  import aoc_pkg::*;
(
  // rate selection
  input wire logic [2:0] rate_code,
  input wire aoc_speed_e speed,
  // decoded multiple, in whole steps plus a half-step flag
  output logic [4:0] multiple,
  output logic half_step
);

  // ---------------------------------------------------------------------------
  // code to single-speed multiple
  // ---------------------------------------------------------------------------
  function automatic logic [4:0] aoc_rate_mult(input logic [2:0] code);
    case (code)
      3'h0: aoc_rate_mult = `AOC_MULT_0;
      3'h1: aoc_rate_mult = `AOC_MULT_1;
      3'h2: aoc_rate_mult = `AOC_MULT_2;
      3'h3: aoc_rate_mult = `AOC_MULT_3;
      3'h4: aoc_rate_mult = `AOC_MULT_4;
      3'h5: aoc_rate_mult = `AOC_MULT_5;
      3'h6: aoc_rate_mult = `AOC_MULT_6;
      default: aoc_rate_mult = `AOC_MULT_7;
    endcase
  endfunction : aoc_rate_mult

  // double speed switches at half the frequency; every multiple is even so
  // the half step never sets today, but it is kept for honesty
  always_comb begin
    logic [4:0] full;
    full = aoc_rate_mult(rate_code);
    if (speed == AOC_SPEED_DOUBLE) begin
      multiple = {1'b0, full[4:1]};
      half_step = full[0];
    end else begin
      multiple = full;
      half_step = 1'b0;
    end
  end

endmodule : aoc_rate_decode

/* File: aoc_output_config_tb.sv */
// aoc_output_config_tb.sv: self-checking bench for the output configuration
// register bank, driving the control port and the speed input directly.
// assumes: aoc_pkg and aoc_cfg.svh compiled first; one 25 MHz clock.
`timescale 1ns/10ps
`include "aoc_cfg.svh"

module aoc_output_config_tb
  import aoc_pkg::*;
;
  // ---------------------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wdata;
    logic ds;
    logic [4:0] mult;
  } aoc_row_s;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic double_speed = 1'b0;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic rsvd_slot_hit;
  aoc_amp_ctl_s amp_ctl;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  aoc_row_s rows [9];

  aoc_output_config dut_u (
    .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .rsvd_slot_hit(rsvd_slot_hit),
    .double_speed(double_speed), .amp_ctl(amp_ctl)
  );

  // 40 ns period clock
  always #20 sys_clk = ~sys_clk;

  // hang guard: the sequence needs well under 200 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // expected controls, worked out from the field layout
  function automatic aoc_amp_ctl_s exp_ctl(input logic [7:0] w, input logic [4:0] m);
    aoc_amp_ctl_s e;
    e.parallel_bridge_mode = w[7];
    e.bridge_tied_mode = ~w[7];
    e.switch_multiple = m;
    e.switch_half_step = 1'b0;
    e.gain_step_code = w[3:2];
    e.gain_code_reserved = (w[3:2] == 2'h3);
    e.mono_source_channel_select = w[1];
    e.feed_left = w[7] & w[1];
    return e;
  endfunction : exp_ctl

  // one-cycle write strobe launched at the falling edge
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
  endtask : bus_write

  // read strobe; answer looked at in the single cycle it stands
  task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    check("rvalid", {15'h0, bus_rvalid}, 16'h1);
    check("rdata", {8'h0, bus_rdata}, {8'h0, exp});
    @(negedge sys_clk);
    check("rvalid_drop", {15'h0, bus_rvalid}, 16'h0);
  endtask : bus_read

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  // every row keeps bit 0 at one and avoids gain code 11
  initial begin
    rows = '{'{8'h01, 1'b0, 5'h06}, '{8'h95, 1'b0, 5'h08}, '{8'ha9, 1'b0, 5'h0a},
             '{8'h33, 1'b0, 5'h0c}, '{8'hc7, 1'b0, 5'h0e}, '{8'h59, 1'b1, 5'h08},
             '{8'he3, 1'b1, 5'h0a}, '{8'hf5, 1'b0, 5'h18}, '{8'hf5, 1'b1, 5'h0c}};
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check("reset_ctl", 16'(amp_ctl), 16'(exp_ctl(8'h51, 5'h10)));
    bus_read(`AOC_ADDR_OUT_CFG, 8'h51);
    // ordinary cases: every rate code, each legal gain step, both topologies
    foreach (rows[i]) begin
      double_speed = rows[i].ds;
      bus_write(`AOC_ADDR_OUT_CFG, rows[i].wdata);
      @(negedge sys_clk);
      check("amp_ctl", 16'(amp_ctl), 16'(exp_ctl(rows[i].wdata, rows[i].mult)));
      bus_read(`AOC_ADDR_OUT_CFG, rows[i].wdata);
    end
    // speed flips alone: multiple follows without any write
    double_speed = 1'b0;
    @(negedge sys_clk);
    check("speed_flip", {11'h0, amp_ctl.switch_multiple}, 16'h18);
    // read and write in one cycle: the read sees the old value
    bus_addr = `AOC_ADDR_OUT_CFG;
    bus_wdata = 8'h29;
    bus_wr = 1'b1;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    check("rd_wr_same", {8'h0, bus_rdata}, 16'hf5);
    bus_read(`AOC_ADDR_OUT_CFG, 8'h29);
    // unmapped address: write dropped, read gives zero; 0x07 is never touched
    bus_write(8'h09, 8'h81);
    bus_read(8'h09, 8'h00);
    bus_read(`AOC_ADDR_OUT_CFG, 8'h29);
    check("no_rsvd_hit", {15'h0, rsvd_slot_hit}, 16'h0);
    // second reset in mid-run restores every field
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check("rerst_ctl", 16'(amp_ctl), 16'(exp_ctl(8'h51, 5'h10)));
    check("rerst_rdata", {8'h0, bus_rdata}, 16'h0);
    bus_read(`AOC_ADDR_OUT_CFG, 8'h51);
    finish_test();
  end
endmodule : aoc_output_config_tb
